// ===== clock_ctrl_defines.svh
// Timing counts, codes and reset values of the clock start-up control
`ifndef CLOCK_CTRL_DEFINES_SVH
`define CLOCK_CTRL_DEFINES_SVH
`define CKS_EXT        4'h0
`define CKS_RC4        4'h2
`define CKS_RC8        4'h4
`define CKS_WDOSC      4'h6
`define SUT_NONE       2'h0
`define SUT_SHORT      2'h1
`define SUT_LONG       2'h2
`define SUT_RSVD       2'h3
`define DEF_CLOCK_SOURCE_SELECT      4'h4
`define DEF_SUT        2'h2
`define DEF_DIV8       1'b0
`define RC_WAKE_CK     16'h0006
`define XTAL_WAKE_CK   16'h4000
`define RESET_CK       16'h000e
`define TOUT_SHORT_WD  16'h0200
`define TOUT_LONG_WD   16'h2000
`define DIV8_RATIO     4'h8
`endif

// ===== clock_ctrl_pkg.sv
// Types shared by the clock start-up control
package clock_ctrl_pkg;
	typedef enum logic [2:0] {
		SRC_EXT, SRC_RC4, SRC_RC8, SRC_WDOSC, SRC_XTAL, SRC_RSVD
	} source_e;
	typedef struct packed {
		logic [3:0] clock_source_select;
		logic [1:0] startup_time_select;
		logic       divide_by_eight_fuse;
	} fuses_s;
	typedef struct packed {
		logic core_clock;
		logic peripheral_clock;
		logic program_memory_clock;
	} clk_en_s;
	typedef enum logic [1:0] {SLP_ACTIVE, SLP_IDLE, SLP_PDOWN, SLP_STBY}
		sleep_t;
endpackage

// ===== clock_source_startup_control.sv
// Clock source decode, start-up timing, prescale and clock gate enables
`include "clock_ctrl_defines.svh"
module clock_source_startup_control
	import clock_ctrl_pkg::*;
#(
	parameter logic [15:0] TOUT_LONG  = `TOUT_LONG_WD,
	parameter logic [15:0] TOUT_SHORT = `TOUT_SHORT_WD
) (
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   clk_en,
	input  wire fuses_s fuse_raw,
	input  wire logic   fuse_valid,
	input  wire logic   wdosc_tick,
	input  wire logic   sleep_req,
	input  wire sleep_t sleep_mode,
	input  wire logic   wake_event,
	input  wire logic   async_int_pin,
	input  wire logic   usi_start_pin,
	output logic        core_run,
	output clk_en_s     gate_en,
	output logic        presc_tick,
	output source_e     source,
	output logic        source_reserved,
	output logic        async_wake,
	output logic        startup_busy
);

	// ************************************
	// Functions
	// ************************************
	function automatic source_e decode_src(input logic [3:0] sel);
		if (sel[3])
			decode_src = SRC_XTAL;
		else if (sel == `CKS_EXT)
			decode_src = SRC_EXT;
		else if (sel == `CKS_RC4)
			decode_src = SRC_RC4;
		else if (sel == `CKS_RC8)
			decode_src = SRC_RC8;
		else if (sel == `CKS_WDOSC)
			decode_src = SRC_WDOSC;
		else
			decode_src = SRC_RSVD;
	endfunction

	// ************************************
	// Start-up sequencer
	// ************************************
	typedef enum {ST_FUSE, ST_RSTCK, ST_TOUT, ST_RUN, ST_SLEEP, ST_WAKE,
		ST_HALT} state_e;

	state_e      state_r, state_nxt;
	fuses_s      fuse_r, fuse_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [2:0]  div_r, div_nxt;
	logic        run_r, run_nxt;
	clk_en_s     gate_r, gate_nxt;
	logic        tick_r, tick_nxt;
	logic        awake_r, awake_nxt;
	source_e     src_r, src_nxt;
	logic        rsv_r, rsv_nxt;
	logic        busy_r, busy_nxt;
	logic [1:0]  sut_code;
	fuses_s      fuse_prog;
	source_e     src_dec;
	logic        is_rc;

	// Fuses arrive active low; store them as programmed=1
	assign fuse_prog = ~fuse_raw;
	// Select and start-up codes are written as raw fuse levels
	assign src_dec   = decode_src(fuse_raw.clock_source_select);
	assign sut_code  = ~fuse_r.startup_time_select;
	assign is_rc     = (src_r == SRC_RC4) || (src_r == SRC_RC8);

	always_comb begin
		state_nxt = state_r;
		fuse_nxt  = fuse_r;
		cnt_nxt   = cnt_r;
		src_nxt   = src_r;
		rsv_nxt   = rsv_r;
		awake_nxt = 1'b0;
		case (state_r)
			ST_FUSE: begin
				if (fuse_valid) begin
					fuse_nxt  = fuse_prog;
					src_nxt   = src_dec;
					rsv_nxt   = (src_dec == SRC_RSVD);
					cnt_nxt   = `RESET_CK;
					state_nxt = ST_RSTCK;
				end
			end
			ST_RSTCK: begin
				if (cnt_r > 16'h0001)
					cnt_nxt = cnt_r - 16'h0001;
				else if (sut_code == `SUT_NONE)
					state_nxt = rsv_r ? ST_HALT : ST_RUN;
				else if (sut_code == `SUT_RSVD && is_rc)
					state_nxt = ST_HALT;
				else begin
					// Long or short time-out on watchdog oscillator
					cnt_nxt = (sut_code == `SUT_LONG)
						? TOUT_LONG : TOUT_SHORT;
					state_nxt = ST_TOUT;
				end
			end
			ST_TOUT: begin
				if (wdosc_tick) begin
					if (cnt_r > 16'h0001)
						cnt_nxt = cnt_r - 16'h0001;
					else
						state_nxt = rsv_r ? ST_HALT : ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_req && sleep_mode != SLP_ACTIVE)
					state_nxt = ST_SLEEP;
			end
			ST_SLEEP: begin
				// pins seen raw, no peripheral clock needed
				if (wake_event || async_int_pin || usi_start_pin) begin
					awake_nxt = 1'b1;
					if (sleep_mode == SLP_IDLE) begin
						state_nxt = ST_RUN;
					end else begin
						cnt_nxt = is_rc ? `RC_WAKE_CK : `XTAL_WAKE_CK;
						state_nxt = ST_WAKE;
					end
				end
			end
			ST_WAKE: begin
				if (cnt_r > 16'h0001)
					cnt_nxt = cnt_r - 16'h0001;
				else
					state_nxt = ST_RUN;
			end
			ST_HALT: state_nxt = ST_HALT;
			default: state_nxt = ST_FUSE;
		endcase
	end

	// ************************************
	// Prescaler and clock gate enables
	// ************************************
	always_comb begin
		div_nxt = div_r + 3'h1;
		// Unprogrammed fuse or non-RC source: tick every cycle; programmed with RC source: one in eight
		if (fuse_r.divide_by_eight_fuse && is_rc)
			tick_nxt = (div_r == 3'(`DIV8_RATIO - 4'h1));
		else
			tick_nxt = 1'b1;
		run_nxt = (state_nxt == ST_RUN);
		gate_nxt.core_clock = run_nxt;
		gate_nxt.program_memory_clock = run_nxt;
		// Peripheral clock stays up in idle only
		gate_nxt.peripheral_clock = run_nxt ||
			(state_nxt == ST_SLEEP && sleep_mode == SLP_IDLE);
		busy_nxt = (state_nxt != ST_RUN) && (state_nxt != ST_SLEEP);
	end

	// Enables only change on clk edges, so gated clocks lose no pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_FUSE;
			fuse_r  <= fuses_s'(~{`DEF_CLOCK_SOURCE_SELECT, `DEF_SUT, `DEF_DIV8});
			cnt_r   <= 16'h0000;
			div_r   <= 3'h0;
			run_r   <= 1'b0;
			gate_r  <= '0;
			tick_r  <= 1'b0;
			awake_r <= 1'b0;
			src_r   <= SRC_RC8;
			rsv_r   <= 1'b0;
			busy_r  <= 1'b1;
		end else if (clk_en) begin
			state_r <= state_nxt;
			fuse_r  <= fuse_nxt;
			cnt_r   <= cnt_nxt;
			div_r   <= div_nxt;
			run_r   <= run_nxt;
			gate_r  <= gate_nxt;
			tick_r  <= tick_nxt && run_nxt;
			awake_r <= awake_nxt;
			src_r   <= src_nxt;
			rsv_r   <= rsv_nxt;
			busy_r  <= busy_nxt;
		end
	end

	assign core_run        = run_r;
	assign gate_en         = gate_r;
	assign presc_tick      = tick_r;
	assign source          = src_r;
	assign source_reserved = rsv_r;
	assign async_wake      = awake_r;
	assign startup_busy    = busy_r;

	// ************************************
	// Assertions
	// ************************************
	property p_core_gate;
		@(posedge clk) disable iff (reset)
		gate_en.core_clock == core_run;
	endproperty
	a_core_gate: assert property (p_core_gate)
		else $error("core gate differs from run");

	property p_flash_core;
		@(posedge clk) disable iff (reset)
		gate_en.program_memory_clock == gate_en.core_clock;
	endproperty
	a_flash_core: assert property (p_flash_core)
		else $error("program memory clock not with core");

	property p_periph_run;
		@(posedge clk) disable iff (reset)
		core_run |-> gate_en.peripheral_clock;
	endproperty
	a_periph_run: assert property (p_periph_run)
		else $error("peripheral clock off while running");

	property p_pdown_off;
		@(posedge clk) disable iff (reset)
		(state_r == ST_SLEEP && sleep_mode == SLP_PDOWN) |->
			!gate_en.peripheral_clock;
	endproperty
	a_pdown_off: assert property (p_pdown_off)
		else $error("peripheral clock on in power-down");

	property p_rc_wake;
		@(posedge clk) disable iff (reset || !clk_en)
		(state_r == ST_SLEEP && state_nxt == ST_WAKE && is_rc) |=>
			!core_run [*6] ##1 core_run;
	endproperty
	a_rc_wake: assert property (p_rc_wake)
		else $error("RC wake count not six cycles");

	property p_rst_ck;
		@(posedge clk) disable iff (reset || !clk_en)
		(state_r == ST_FUSE && fuse_valid) |=> !core_run [*8];
	endproperty
	a_rst_ck: assert property (p_rst_ck)
		else $error("ran before reset delay");

	property p_tout_load;
		@(posedge clk) disable iff (reset)
		(state_r == ST_RSTCK && state_nxt == ST_TOUT && clk_en) |=>
			(cnt_r == TOUT_LONG || cnt_r == TOUT_SHORT);
	endproperty
	a_tout_load: assert property (p_tout_load)
		else $error("bad time-out load");

	property p_fuse_inv;
		@(posedge clk) disable iff (reset || !clk_en)
		(state_r == ST_FUSE && fuse_valid) |=>
			fuse_r == ~$past(fuse_raw);
	endproperty
	a_fuse_inv: assert property (p_fuse_inv)
		else $error("fuse polarity wrong");

	property p_div8;
		@(posedge clk) disable iff (reset || !clk_en)
		(presc_tick && fuse_r.divide_by_eight_fuse && is_rc && core_run
			&& $stable(state_r)) |=> !presc_tick;
	endproperty
	a_div8: assert property (p_div8)
		else $error("divide by eight ticks too often");

	property p_async_wake;
		@(posedge clk) disable iff (reset)
		(state_r == ST_SLEEP && clk_en &&
			(wake_event || async_int_pin || usi_start_pin)) |=> async_wake;
	endproperty
	a_async_wake: assert property (p_async_wake)
		else $error("wake pin not seen in sleep");

	property p_halt;
		@(posedge clk) disable iff (reset)
		(state_r == ST_HALT) |-> (!core_run && startup_busy);
	endproperty
	a_halt: assert property (p_halt)
		else $error("core released from reserved setting");

	property p_busy_run;
		@(posedge clk) disable iff (reset)
		core_run |-> !startup_busy;
	endproperty
	a_busy_run: assert property (p_busy_run)
		else $error("core runs during start-up");

	c_boot: cover property (@(posedge clk) $rose(core_run));
	c_sleep: cover property (@(posedge clk) state_r == ST_SLEEP);
	c_wake: cover property (@(posedge clk) state_r == ST_WAKE);
	c_halt: cover property (@(posedge clk) state_r == ST_HALT);

endmodule // clock_source_startup_control

// ===== osc_fuse_model.sv
// Fuse storage and watchdog oscillator model
module osc_fuse_model
	import clock_ctrl_pkg::*;
#(
	parameter int PER = 4
) (
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire fuses_s fuse_set,
	output fuses_s      fuse_raw,
	output logic        fuse_valid,
	output logic        wdosc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	initial begin
		fuse_raw = fuse_set;
		fuse_valid = 1'b0;
		wdosc_tick = 1'b0;
	end
	// ****************
	// Fuse read-out unsettled in reset, so show the inverse pattern
	// ****************
	always @(posedge clk) begin
		n <= reset ? 0 : (n + 1) % PER;
		wdosc_tick <= #1 !reset && n == PER - 1;
		fuse_valid <= #1 !reset;
		fuse_raw <= #1 reset ? ~fuse_set : fuse_set;
	end
endmodule // osc_fuse_model

// ===== clock_source_startup_control_tb_top.sv
// Self-checking bench of the clock start-up control
module clock_source_startup_control_tb_top import clock_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic    clk = 0, reset = 1, sleep_req = 0, wake_event = 0;
	logic    clk_en = 1;
	logic    async_int_pin = 0, usi_start_pin = 0, fuse_valid, tick;
	sleep_t  sleep_mode = SLP_ACTIVE;
	fuses_s  fuse_set = '{4'h4, 2'h2, 1'b0};
	fuses_s  fuse_raw;
	clk_en_s gate_en;
	source_e source;
	logic    core_run, presc_tick, source_reserved, async_wake, busy;
	int      n_fail = 0, check_count = 0, cyc = 0, t, wakes;
	always #5 clk = ~clk;
	osc_fuse_model #(.PER(4)) osc_fuse_model_i (.clk(clk),
		.reset(reset), .fuse_set(fuse_set), .fuse_raw(fuse_raw),
		.fuse_valid(fuse_valid), .wdosc_tick(tick));
	clock_source_startup_control #(.TOUT_LONG(16'h0008),
		.TOUT_SHORT(16'h0004)) clock_source_startup_control_i (
		.clk(clk), .reset(reset), .clk_en(clk_en), .fuse_raw(fuse_raw),
		.fuse_valid(fuse_valid), .wdosc_tick(tick),
		.sleep_req(sleep_req), .sleep_mode(sleep_mode),
		.wake_event(wake_event), .async_int_pin(async_int_pin),
		.usi_start_pin(usi_start_pin), .core_run(core_run),
		.gate_en(gate_en), .presc_tick(presc_tick), .source(source),
		.source_reserved(source_reserved), .async_wake(async_wake),
		.startup_busy(busy));
	// ****************
	// Tasks
	// ****************
	task automatic chk_v(string nm, logic [4:0] e, logic [4:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_src(string nm, source_e e, source_e g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic boot(fuses_s f);
		fuse_set = f;
		reset = 1;
		sleep_mode = SLP_ACTIVE;
		step(4);
		chk_v("gate_en rst", 5'h0, 5'(gate_en));
		chk_v("busy rst", 5'h1, 5'(busy));
		chk_src("source rst", SRC_RC8, source);
		reset = 0;
		t = 0;
		while (core_run !== 1'b1 && t < 200) begin
			step(1);
			t++;
		end
	endtask
	task automatic ticks(logic [4:0] e);
		int k;
		k = 0;
		repeat (16) begin
			step(1);
			if (presc_tick === 1'b1) k++;
		end
		chk_v("presc_tick", e, 5'(k));
	endtask
	task automatic slp(sleep_t m);
		sleep_mode = m;
		sleep_req = 1;
		step(3);
		sleep_req = 0;
	endtask
	function automatic source_e exp_src(int c);
		if (c >= 8) return SRC_XTAL;
		if (c % 2) return SRC_RSVD;
		return source_e'(c / 2);
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	always @(posedge clk) if (async_wake === 1'b1) wakes++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results;
		end
	end
	initial begin
		boot('{4'h4, 2'h2, 1'b0});
		chk_v("long delay", 5'h1, 5'(t >= 28 && t <= 54));
		chk_src("source", SRC_RC8, source);
		chk_v("gate_en", 5'h7, 5'(gate_en));
		ticks(5'h2);
		boot('{4'h4, 2'h1, 1'b1});
		chk_v("short delay", 5'h1, 5'(t >= 14 && t <= 38));
		ticks(5'h10);
		boot('{4'h2, 2'h0, 1'b1});
		chk_v("base delay", 5'h1, 5'(t >= 14 && t <= 20));
		slp(SLP_IDLE);
		chk_v("idle gates", 5'h2, 5'(gate_en));
		chk_v("idle run", 5'h0, 5'(core_run));
		usi_start_pin = 1;
		step(1);
		usi_start_pin = 0;
		step(2);
		chk_v("usi wake", 5'h1, 5'(core_run));
		slp(SLP_PDOWN);
		chk_v("pdown gates", 5'h0, 5'(gate_en));
		wakes = 0;
		async_int_pin = 1;
		step(1);
		async_int_pin = 0;
		step(3);
		chk_v("wake early", 5'h0, 5'(core_run));
		// Clock enable low freezes the wake count
		clk_en = 0;
		step(8);
		chk_v("frozen wake", 5'h0, 5'(core_run));
		clk_en = 1;
		step(8);
		chk_v("wake run", 5'h1, 5'(core_run));
		chk_v("async_wake", 5'h1, 5'(wakes));
		for (int c = 0; c < 16; c++) begin
			boot('{4'(c), 2'h0, 1'b1});
			chk_src("decode", exp_src(c), source);
			chk_v("reserved", 5'(c < 8 && c[0]), 5'(source_reserved));
			chk_v("halt", 5'(!(c < 8 && c[0])), 5'(core_run));
		end
		// Reserved start-up code with an RC source must never release the core
		boot('{4'h4, 2'h3, 1'b1});
		chk_v("sut reserved", 5'h0, 5'(core_run));
		results;
	end
endmodule // clock_source_startup_control_tb_top
